// File: primary_bus_hold_logic.sv
// Primary bus hold handshake, bus cycle sequencer and posted-write slot.
// Assumes request pins arrive synchronous to clk; the testbench reads
// the bus outputs directly and checks the active-low output enables.
`timescale 1ns/10ps

// Behaviour
// - The hold request may arrive at any time; a late one is answered one phase cycle later.
// - The request is sampled at the phase clock falling edge and the acknowledge changes only after it.
// - The disable input beats the request, ends any hold and refuses new ones.
// - While held the block makes no bus access and stalls only a bus request.
// - During a hold one write may be posted; a second write stalls.
// - The acknowledge goes low for a request and stays low one phase cycle after release.
// - While granted, strobe, read/write, address and data are floated; the first three are driven again after, data only on writes.
module primary_bus_hold_logic #(
  parameter int AW       = hold_pkg::ADDR_W,
  parameter int DW       = hold_pkg::DATA_W,
  parameter int STROBE_N = hold_pkg::STROBE_PHASES
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          hold_req_n,
  input  wire logic          request_override_disable,
  input  wire logic          cpu_req,
  input  wire logic          cpu_we,
  input  wire logic [AW-1:0] cpu_addr,
  input  wire logic [DW-1:0] cpu_wdata,
  output logic               cpu_done,
  output logic [DW-1:0]      cpu_rdata,
  output logic               primary_phase_clock,
  output logic               bus_grant_ack_n,
  output logic               bus_strobe_n,
  output logic               bus_strobe_oe_n,
  output logic               bus_rw,
  output logic               bus_rw_oe_n,
  output logic [AW-1:0]      bus_addr,
  output logic               bus_addr_oe_n,
  output logic [DW-1:0]      bus_data_out,
  input  wire logic [DW-1:0] bus_data_in,
  output logic               bus_data_oe_n
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [1:0] {IDLE, CYCLE, HOLD} state_e;

  typedef struct packed {
    state_e                     st;
    logic                       tail;
    logic [hold_pkg::CNT_W-1:0] cnt;
    logic                       cur_we;
    logic                       cur_cpu;
    logic [AW-1:0]              cur_addr;
    logic [DW-1:0]              cur_data;
    logic                       pend_v;
    logic [AW-1:0]              pend_addr;
    logic [DW-1:0]              pend_data;
    logic                       done;
    logic [DW-1:0]              rdata;
  } hold_s;

  hold_s cur_ff;
  hold_s nxt_ff;
  logic  fall_en;
  logic  req_seen;

  phase_clock_gen #(
    .HALF_CYC (hold_pkg::PHASE_HALF_CYC)
  ) u_div (
    .clk                 (clk),
    .reset               (reset),
    .primary_phase_clock (primary_phase_clock),
    .phase_fall_en       (fall_en)
  );

  // Only looked at on the falling-edge pulse; a request that misses it
  // waits for the next phase cycle
  assign req_seen = ~hold_req_n;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    nxt_ff      = cur_ff;
    nxt_ff.done = 1'b0;
    unique case (cur_ff.st)
      IDLE: begin
        if (fall_en) begin
          if (req_seen && !request_override_disable) begin
            nxt_ff.st   = HOLD;
            nxt_ff.tail = 1'b0;
          end else if (cur_ff.pend_v) begin
            // Posted write drains before any new access
            nxt_ff.st       = CYCLE;
            nxt_ff.cnt      = '0;
            nxt_ff.cur_we   = 1'b1;
            nxt_ff.cur_cpu  = 1'b0;
            nxt_ff.cur_addr = cur_ff.pend_addr;
            nxt_ff.cur_data = cur_ff.pend_data;
            nxt_ff.pend_v   = 1'b0;
          end else if (cpu_req && !cur_ff.done) begin
            nxt_ff.st       = CYCLE;
            nxt_ff.cnt      = '0;
            nxt_ff.cur_we   = cpu_we;
            nxt_ff.cur_cpu  = 1'b1;
            nxt_ff.cur_addr = cpu_addr;
            nxt_ff.cur_data = cpu_wdata;
          end
        end
      end
      CYCLE: begin
        // Hold is not looked at here: the cycle always completes
        if (fall_en) begin
          if (cur_ff.cnt == hold_pkg::CNT_W'(STROBE_N - 1)) begin
            nxt_ff.st   = IDLE;
            nxt_ff.done = cur_ff.cur_cpu;
            if (!cur_ff.cur_we) begin
              nxt_ff.rdata = bus_data_in;
            end
          end else begin
            nxt_ff.cnt = cur_ff.cnt + hold_pkg::CNT_W'(1);
          end
        end
      end
      HOLD: begin
        // One write slot keeps the program running through the hold
        if (cpu_req && cpu_we && !cur_ff.pend_v && !cur_ff.done) begin
          nxt_ff.pend_v    = 1'b1;
          nxt_ff.pend_addr = cpu_addr;
          nxt_ff.pend_data = cpu_wdata;
          nxt_ff.done      = 1'b1;
        end
        if (fall_en) begin
          if (request_override_disable) begin
            nxt_ff.st = IDLE;
          end else if (req_seen) begin
            nxt_ff.tail = 1'b0;
          end else if (cur_ff.tail) begin
            nxt_ff.st = IDLE;
          end else begin
            nxt_ff.tail = 1'b1;
          end
        end
      end
      // Fourth code of the state field is never reached; recover to idle
      default: begin
        nxt_ff.st = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff    <= '0;
      cur_ff.st <= IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ***************************************************************
  // Pins
  // ***************************************************************
  assign bus_grant_ack_n = (cur_ff.st != HOLD);
  assign bus_strobe_n    = (cur_ff.st != CYCLE);
  assign bus_rw          = ~cur_ff.cur_we;
  assign bus_addr        = cur_ff.cur_addr;
  assign bus_data_out    = cur_ff.cur_data;
  assign bus_strobe_oe_n = (cur_ff.st == HOLD);
  assign bus_rw_oe_n     = (cur_ff.st == HOLD);
  assign bus_addr_oe_n   = (cur_ff.st == HOLD);
  // Data is driven only while writing, and never under a grant
  assign bus_data_oe_n   = !(cur_ff.st == CYCLE && cur_ff.cur_we);
  assign cpu_done        = cur_ff.done;
  assign cpu_rdata       = cur_ff.rdata;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_grant_cause;
    fall_en && req_seen && !request_override_disable && cur_ff.st == IDLE;
  endsequence

  sequence s_release_seen;
    fall_en && cur_ff.st == HOLD && !req_seen && !request_override_disable
      && !cur_ff.tail;
  endsequence

  a_grant_follows: assert property (
    @(posedge clk) disable iff (reset)
    s_grant_cause |=> !bus_grant_ack_n
  ) else $error("grant not given after sampled request");

  a_ack_on_fall: assert property (
    @(posedge clk) disable iff (reset)
    $changed(bus_grant_ack_n) |-> $past(fall_en)
  ) else $error("acknowledge changed away from a falling edge");

  a_disable_wins: assert property (
    @(posedge clk) disable iff (reset)
    fall_en && request_override_disable |=> bus_grant_ack_n
  ) else $error("hold held against disable");

  a_read_stalls: assert property (
    @(posedge clk) disable iff (reset)
    cur_ff.st == HOLD && cpu_req && !cpu_we |=> !cpu_done && bus_strobe_n
  ) else $error("read completed during hold");

  a_second_write: assert property (
    @(posedge clk) disable iff (reset)
    cur_ff.st == HOLD && cur_ff.pend_v && cpu_req && cpu_we |=> !cpu_done
  ) else $error("second write accepted during hold");

  a_ack_tail: assert property (
    @(posedge clk) disable iff (reset)
    s_release_seen |=> !bus_grant_ack_n [*4]
  ) else $error("acknowledge dropped without the extra cycle");

  a_float_held: assert property (
    @(posedge clk) disable iff (reset)
    !bus_grant_ack_n |-> bus_strobe_oe_n && bus_rw_oe_n && bus_addr_oe_n
      && bus_data_oe_n
  ) else $error("bus driven while granted");

  a_cycle_first: assert property (
    @(posedge clk) disable iff (reset)
    cur_ff.st == CYCLE |=> bus_grant_ack_n
  ) else $error("grant given during a bus cycle");

endmodule // primary_bus_hold_logic

// File: hold_pkg.sv
// Constants shared by the primary bus hold logic and its phase divider.
// Assumes a single 200 MHz system clock drives every file.
package hold_pkg;

  localparam int ADDR_W         = 24;
  localparam int DATA_W         = 32;
  // System clocks per half period of the phase clock
  localparam int PHASE_HALF_CYC = 2;
  // Phase-clock cycles that the strobe stays low in one bus cycle
  localparam int STROBE_PHASES  = 1;
  localparam int CNT_W          = 8;
  localparam logic RESET_LEVEL  = 1'b0;

endpackage

// File: phase_clock_gen.sv
// Phase clock divider for the primary bus hold logic.
// Assumes clk is the only clock; the phase clock is a plain output.
`timescale 1ns/10ps

module phase_clock_gen #(
  parameter int HALF_CYC = hold_pkg::PHASE_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      primary_phase_clock,
  output logic      phase_fall_en
);

  typedef struct packed {
    logic [hold_pkg::CNT_W-1:0] cnt;
    logic                       level;
    logic                       fall;
  } div_s;

  div_s cur_ff;
  div_s nxt_ff;

  always_comb begin
    nxt_ff      = cur_ff;
    nxt_ff.fall = 1'b0;
    if (cur_ff.cnt == hold_pkg::CNT_W'(HALF_CYC - 1)) begin
      nxt_ff.cnt   = '0;
      nxt_ff.level = ~cur_ff.level;
      // Pulse lands in the same cycle as the falling level
      nxt_ff.fall  = cur_ff.level;
    end else begin
      nxt_ff.cnt = cur_ff.cnt + hold_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff <= '{cnt: '0, level: hold_pkg::RESET_LEVEL, fall: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign primary_phase_clock = cur_ff.level;
  assign phase_fall_en       = cur_ff.fall;

endmodule // phase_clock_gen

// File: bus_master_model.sv
// External master that asks for the primary bus and answers reads.
// Assumes the bench sets want_hold and rd_val at clk rising edges.
`timescale 1ns/10ps

module bus_master_model (
  input  wire logic                         clk,
  input  wire logic                         want_hold,
  input  wire logic [hold_pkg::DATA_W-1:0]  rd_val,
  input  wire logic                         bus_strobe_n,
  output logic                              hold_req_n,
  output logic [hold_pkg::DATA_W-1:0]       bus_data_in
);
  // Released data bus toggles, so a stale sample cannot look valid
  always @(posedge clk) begin
    hold_req_n  <= !want_hold;
    bus_data_in <= !bus_strobe_n ? rd_val : ~bus_data_in;
  end
endmodule // bus_master_model

// File: primary_bus_hold_logic_tb_top.sv
// Self-checking bench for the primary bus hold logic.
// Assumes the hold package and the bus master model are compiled first.
`timescale 1ns/10ps

module primary_bus_hold_logic_tb_top;
  logic clk, reset, hrq_n, dis, want, cpu_req, cpu_we, cpu_done, ph;
  logic ack_n, stb_n, stb_oe, rw, rw_oe, a_oe, d_oe;
  logic [23:0] addr, bus_addr, la;
  logic [31:0] wd, rd, dout, din, rv, lw, w1, w2, r;
  int seed, n_fail, checks, n, n2, k, i, cyc_n;

  primary_bus_hold_logic uut (.clk(clk), .reset(reset),
    .hold_req_n(hrq_n), .request_override_disable(dis),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(addr), .cpu_wdata(wd),
    .cpu_done(cpu_done), .cpu_rdata(rd), .primary_phase_clock(ph),
    .bus_grant_ack_n(ack_n), .bus_strobe_n(stb_n),
    .bus_strobe_oe_n(stb_oe), .bus_rw(rw), .bus_rw_oe_n(rw_oe),
    .bus_addr(bus_addr), .bus_addr_oe_n(a_oe), .bus_data_out(dout),
    .bus_data_in(din), .bus_data_oe_n(d_oe));
  bus_master_model bm (.clk(clk), .want_hold(want), .rd_val(rv),
    .bus_strobe_n(stb_n), .hold_req_n(hrq_n), .bus_data_in(din));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Last address and write word seen on the bus under the strobe
  always @(negedge clk) begin
    if (stb_n === 1'b0) begin
      la <= bus_addr;
      if (rw === 1'b0 && d_oe === 1'b0) lw <= dout;
    end
  end
  // Phase clock samples from its rising edge: high for half cycles
  function automatic logic [3:0] exp_phase(input int half);
    exp_phase = '0;
    for (int j = 0; j < 4; j++) exp_phase[j] = (j < half);
  endfunction
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic we, input logic [31:0] d, output int c);
    c = 0;
    r = $random(seed);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_we  <= we;
    addr    <= r[23:0];
    wd      <= d;
    do begin
      @(negedge clk);
      c++;
    end while (cpu_done !== 1'b1 && c < 300);
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask
  task automatic wack(input logic v, output int c);
    c = 0;
    while (ack_n !== v && c < 50) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic hold(input logic v);
    @(posedge clk);
    want <= v;
  endtask
  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    seed = 79872;
    {n_fail, checks, cyc_n} = '0;
    {reset, want, dis, cpu_req, cpu_we, addr, wd, rv} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk) rv <= $random(seed);
      acc(1'b0, 32'h0, n);
      chk(rd, rv);
      chk(la, addr);
    end
    $display("test reads done");
    // Hold asked for in mid read: the read ends first
    @(posedge clk) rv <= $random(seed);
    n2 = -1;
    fork acc(1'b0, 32'h0, n2); join_none
    repeat (2) hold(1'b1);
    wack(1'b0, k);
    chk(n2 != -1, 1);
    chk(rd, rv);
    chk(k <= 9, 1);
    chk({stb_oe, rw_oe, a_oe, d_oe}, 4'hF);
    acc(1'b1, $random(seed), n);
    chk(n <= 3, 1);
    w1 = wd;
    w2 = $random(seed);
    n2 = -1;
    fork acc(1'b1, w2, n2); join_none
    repeat (20) @(negedge clk);
    chk(n2, -1);
    chk(ack_n, 0);
    hold(1'b0);
    wack(1'b1, k);
    chk(k >= 5 && k <= 10, 1);
    chk({stb_oe, rw_oe, a_oe}, 3'h0);
    repeat (6) @(negedge clk);
    chk(lw, w1);
    for (k = 0; k < 40 && n2 == -1; k++) @(negedge clk);
    repeat (6) @(negedge clk);
    chk(lw, w2);
    $display("test hold done");
    // Read reached while held stalls until release
    hold(1'b1);
    wack(1'b0, k);
    @(posedge clk) rv <= $random(seed);
    n2 = -1;
    fork acc(1'b0, 32'h0, n2); join_none
    repeat (20) @(negedge clk);
    chk(n2, -1);
    hold(1'b0);
    for (k = 0; k < 60 && n2 == -1; k++) @(negedge clk);
    chk(rd, rv);
    chk(la, addr);
    $display("test stall done");
    hold(1'b1);
    wack(1'b0, k);
    @(posedge clk) dis <= 1'b1;
    wack(1'b1, k);
    chk(k <= 6, 1);
    repeat (20) @(negedge clk);
    chk(ack_n, 1);
    @(posedge clk) dis <= 1'b0;
    hold(1'b0);
    @(posedge ph);
    for (k = 0; k < 4; k++) @(negedge clk) r[k] = ph;
    chk(r[3:0], exp_phase(hold_pkg::PHASE_HALF_CYC));
    $display("test disable done");
    end_sim();
  end
endmodule // primary_bus_hold_logic_tb_top
